// file: common/fpmc_params.svh
// front-panel menu controller: offsets, codes and timing counts as macros
// assumes a 100 MHz system clock; included by the button and top-level design files
`ifndef FPMC_PARAMS_SVH
`define FPMC_PARAMS_SVH

`define FPMC_CLK_MHZ 100
`define FPMC_MS_CYC(ms) ((ms) * `FPMC_CLK_MHZ * 1000)
`define FPMC_DEB_TIME_MS 10
`define FPMC_INIT_TIME_MS 1000
`define FPMC_PAGE_HOLD_MS 2000
`define FPMC_BLINK_TIME_MS 250
`define FPMC_ACK_TIME_MS 1000
`define FPMC_DEB_CYC `FPMC_MS_CYC(`FPMC_DEB_TIME_MS)
`define FPMC_INIT_CYC `FPMC_MS_CYC(`FPMC_INIT_TIME_MS)
`define FPMC_PAGE_HOLD_CYC `FPMC_MS_CYC(`FPMC_PAGE_HOLD_MS)
`define FPMC_BLINK_CYC `FPMC_MS_CYC(`FPMC_BLINK_TIME_MS)
`define FPMC_ACK_CYC `FPMC_MS_CYC(`FPMC_ACK_TIME_MS)

`define FPMC_BTN_N 5
`define FPMC_BTN_MODE 0
`define FPMC_BTN_UP 1
`define FPMC_BTN_DOWN 2
`define FPMC_BTN_SHIFT 3
`define FPMC_BTN_SET 4

`define FPMC_CAT_MON 2'h3
`define FPMC_CUR_MAX 3'h4

`define FPMC_CH_E 5'h0E
`define FPMC_CH_D 5'h0D
`define FPMC_CH_C 5'h0C
`define FPMC_CH_F 5'h0F
`define FPMC_CH_BLANK 5'h10
`define FPMC_CH_MINUS 5'h11
`define FPMC_CH_N 5'h12
`define FPMC_CH_R 5'h13
`define FPMC_CH_I 5'h14
`define FPMC_CH_T 5'h15
`define FPMC_CH_U 5'h16
`define FPMC_CH_OUT 5'h17
`define FPMC_CH_IN 5'h18

`endif

// file: common/fpmc_pkg.sv
// front-panel menu controller: shared types
// constants live in fpmc_params.svh
package fpmc_pkg;
  typedef enum logic [5:0] {
    ST_INIT = 6'b000001,
    ST_STATUS = 6'b000010,
    ST_GROUP = 6'b000100,
    ST_OFFSET = 6'b001000,
    ST_VALUE = 6'b010000,
    ST_FAULT = 6'b100000
  } fpmc_state_e;
  typedef enum logic [1:0] {
    CODE_NOT_READY = 2'h0,
    CODE_READY = 2'h1,
    CODE_RUNNING = 2'h2,
    CODE_SPARE = 2'h3
  } fpmc_servo_e;
  typedef enum logic [2:0] {
    LINK_NONE = 3'h0,
    LINK_INIT = 3'h1,
    LINK_PREOP = 3'h2,
    LINK_SAFEOP = 3'h3,
    LINK_OP = 3'h4
  } fpmc_comm_e;
  typedef logic [4:0] fpmc_char_t;
endpackage

// file: design/fpmc_button.sv
// one push button: synchroniser, debounce, press / hold / repeat events
// assumes an active-high raw button level on the system clock
`timescale 1ns/100ps
`include "fpmc_params.svh"
module fpmc_button #(
  parameter int unsigned DEB_CYCLES = `FPMC_DEB_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // raw button and thresholds
  input wire logic btn_i,
  input wire logic [23:0] hold_cycles_i,
  input wire logic [23:0] rep_cycles_i,
  // debounced level and one-cycle events
  output logic level_o,
  output logic press_o,
  output logic hold_o,
  output logic rep_o
);
  logic sync1, sync2, lvl_q, held;
  logic [31:0] deb_cnt;
  logic [23:0] hold_cnt, rep_cnt;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= btn_i;
      sync2 <= sync1;
    end
  end

  // a level must stand for the whole window before it is accepted
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      level_o <= 1'b0;
      deb_cnt <= 32'h0;
    end else if (sync2 == level_o) begin
      deb_cnt <= 32'h0;
    end else if (deb_cnt == 32'(DEB_CYCLES - 1)) begin
      level_o <= sync2; // R24
      deb_cnt <= 32'h0;
    end else begin
      deb_cnt <= deb_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lvl_q <= 1'b0;
      held <= 1'b0;
      hold_cnt <= 24'h0;
      rep_cnt <= 24'h0;
      press_o <= 1'b0;
      hold_o <= 1'b0;
      rep_o <= 1'b0;
    end else begin
      lvl_q <= level_o;
      press_o <= 1'b0;
      hold_o <= 1'b0;
      rep_o <= 1'b0;
      if (level_o) begin
        if (!held) begin
          if (hold_cnt == hold_cycles_i) begin
            held <= 1'b1; // R24
            hold_o <= 1'b1;
            rep_cnt <= 24'h0;
          end else begin
            hold_cnt <= hold_cnt + 24'h1;
          end
        end else if (rep_cnt == rep_cycles_i) begin
          rep_o <= 1'b1; // R25
          rep_cnt <= 24'h0;
        end else begin
          rep_cnt <= rep_cnt + 24'h1;
        end
      end else begin
        press_o <= lvl_q & ~held; // R25
        held <= 1'b0;
        hold_cnt <= 24'h0;
        rep_cnt <= 24'h0;
      end
    end
  end

  press_once_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    press_o |=> !press_o) else $error("press event longer than one cycle"); // R25
endmodule

// file: design/fpmc_bcd.sv
// binary to ten-digit decimal, shift-and-add-three, one result per 33 cycles
// assumes the input is a magnitude that holds still for a conversion
`timescale 1ns/100ps
module fpmc_bcd (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // value in, digits out
  input wire logic [31:0] bin_i,
  output logic [39:0] bcd_o
);
  logic [31:0] sh;
  logic [39:0] acc, adj;
  logic [5:0] cnt;

  always_comb begin
    for (int i = 0; i < 10; i++) begin
      adj[4*i +: 4] = (acc[4*i +: 4] >= 4'h5) ? acc[4*i +: 4] + 4'h3 : acc[4*i +: 4];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sh <= 32'h0;
      acc <= 40'h0;
      cnt <= 6'h0;
    end else if (cnt == 6'h0) begin
      sh <= bin_i;
      acc <= 40'h0;
      cnt <= 6'h1;
    end else begin
      acc <= {adj[38:0], sh[31]};
      sh <= {sh[30:0], 1'b0};
      cnt <= (cnt == 6'h20) ? 6'h0 : cnt + 6'h1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bcd_o <= 40'h0;
    end else if (cnt == 6'h20) begin
      bcd_o <= {adj[38:0], sh[31]};
    end
  end
endmodule

// file: design/fpmc_top.sv
// front-panel menu controller: buttons, four-level menu, five-digit display
// assumes synchronous status inputs and a parameter store outside the block
`timescale 1ns/100ps
`include "fpmc_params.svh"
// What this block does
// R1: mode press changes level; hold steps group
// R2: up/down step status items or value
// R3: shift moves cursor; hold jogs or pages
// R4: set descends a level or stores setpoint
// R5: show Init, then status without input
// R6: monitored value while motor rotates
// R7: selecting monitor switches to monitored display
// R8: fault display blinks; set stops, mode leaves
// R9: group shown hex with category letter
// R10: group level: set enters offset, mode returns
// R11: offset in hex; set edits, mode returns
// R12: value decimal; adjust, store, acknowledge, return
// R13: top level cycles modes; mode enters group
// R14: brake segment lit only for brake model
// R15: port symbol blank, out or in
// R16: comm digit 0,1,2,4,8 by link state
// R17: running mode digit, seven motion modes
// R18: servo field: not ready, ready, running codes
// R19: signed four digits, minus and point
// R20: unsigned five digits on one page
// R21: long values paged low first with index
// R22: page advances after shift held over 2 s
// R23: show highest severity fault code
// R24: buttons synchronised, debounced, hold threshold programmable
// R25: one event per press, programmable repeat rate
module fpmc_top #(
  parameter int unsigned DEB_CYCLES = `FPMC_DEB_CYC,
  parameter int unsigned INIT_CYCLES = `FPMC_INIT_CYC,
  parameter int unsigned PAGE_HOLD_CYCLES = `FPMC_PAGE_HOLD_CYC,
  parameter int unsigned BLINK_CYCLES = `FPMC_BLINK_CYC,
  parameter int unsigned ACK_CYCLES = `FPMC_ACK_CYC
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // buttons, high while pressed
  input wire logic BTN_MODE_I,
  input wire logic BTN_UP_I,
  input wire logic BTN_DOWN_I,
  input wire logic BTN_SHIFT_I,
  input wire logic BTN_SET_I,
  input wire logic [23:0] HOLD_CYCLES_I,
  input wire logic [23:0] REPEAT_CYCLES_I,
  // drive status
  input wire logic HAS_BRAKE_I,
  input wire logic PORT_OUT_LINK_I,
  input wire logic PORT_IN_LINK_I,
  input wire fpmc_pkg::fpmc_comm_e COMM_STATE_I,
  input wire logic [2:0] RUN_MODE_I,
  input wire fpmc_pkg::fpmc_servo_e SERVO_STATE_I,
  input wire logic MOTOR_ROTATING_I,
  input wire logic [7:0] FAULT_REQ_I,
  // values to show
  input wire logic [31:0] MON_VALUE_I,
  input wire logic MON_SIGNED_I,
  input wire logic [31:0] PARAM_RDATA_I,
  input wire logic PARAM_SIGNED_I,
  // parameter access
  output logic [7:0] PARAM_GROUP_O,
  output logic [7:0] PARAM_OFFSET_O,
  output logic [31:0] PARAM_WDATA_O,
  output logic PARAM_STORE_O,
  output logic MON_SELECT_O,
  output logic [7:0] MON_GROUP_O,
  output logic [7:0] MON_OFFSET_O,
  output logic JOG_O,
  // display, digit 4 leftmost, bit 7 of each digit is its point
  output logic [39:0] SEG_O
);
  import fpmc_pkg::*;

  fpmc_state_e state;
  logic [4:0] lvl, prs, hld, rep, raw;
  logic m_press, m_step, up_step, dn_step, sh_press, sh_hold, set_ev, fault_new;
  logic [7:0] fault_q;
  logic [31:0] init_cnt, edit, blink_cnt, ack_cnt, page_cnt, num_src, mag;
  logic [2:0] cursor, fault_idx;
  logic disp_mon, blink, blink_ph, ack, page_done, show_mon, neg, last_pg;
  logic [1:0] page, npages;
  logic [39:0] bcd, next_seg;
  logic [47:0] bcd_pad;
  fpmc_char_t [4:0] ch;
  logic [4:0] dp;

  assign raw = {BTN_SET_I, BTN_SHIFT_I, BTN_DOWN_I, BTN_UP_I, BTN_MODE_I};
  for (genvar g = 0; g < `FPMC_BTN_N; g++) begin : g_btn
    fpmc_button #(.DEB_CYCLES(DEB_CYCLES)) u_btn (
      .clk_i(CLK_I),
      .nrst_i(NRST_I),
      .btn_i(raw[g]),
      .hold_cycles_i(HOLD_CYCLES_I),
      .rep_cycles_i(REPEAT_CYCLES_I),
      .level_o(lvl[g]),
      .press_o(prs[g]),
      .hold_o(hld[g]),
      .rep_o(rep[g])
    );
  end

  assign m_press = prs[`FPMC_BTN_MODE];
  assign m_step = hld[`FPMC_BTN_MODE] | rep[`FPMC_BTN_MODE];
  assign up_step = prs[`FPMC_BTN_UP] | hld[`FPMC_BTN_UP] | rep[`FPMC_BTN_UP];
  assign dn_step = prs[`FPMC_BTN_DOWN] | hld[`FPMC_BTN_DOWN] | rep[`FPMC_BTN_DOWN];
  assign sh_press = prs[`FPMC_BTN_SHIFT];
  assign sh_hold = hld[`FPMC_BTN_SHIFT];
  assign set_ev = prs[`FPMC_BTN_SET] | hld[`FPMC_BTN_SET];
  assign fault_new = |(FAULT_REQ_I & ~fault_q) && state != ST_INIT;

  function automatic logic [31:0] pow10(input logic [2:0] c);
    case (c)
      3'h1: pow10 = 32'hA;
      3'h2: pow10 = 32'h64;
      3'h3: pow10 = 32'h3E8;
      3'h4: pow10 = 32'h2710;
      default: pow10 = 32'h1;
    endcase
  endfunction

  function automatic logic [6:0] glyph(input fpmc_char_t c);
    case (c)
      5'h00: glyph = 7'h3F;
      5'h01: glyph = 7'h06;
      5'h02: glyph = 7'h5B;
      5'h03: glyph = 7'h4F;
      5'h04: glyph = 7'h66;
      5'h05: glyph = 7'h6D;
      5'h06: glyph = 7'h7D;
      5'h07: glyph = 7'h07;
      5'h08: glyph = 7'h7F;
      5'h09: glyph = 7'h6F;
      5'h0A: glyph = 7'h77;
      5'h0B: glyph = 7'h7C;
      5'h0C: glyph = 7'h39;
      5'h0D: glyph = 7'h5E;
      5'h0E: glyph = 7'h79;
      5'h0F: glyph = 7'h71;
      `FPMC_CH_MINUS: glyph = 7'h40;
      `FPMC_CH_N: glyph = 7'h54;
      `FPMC_CH_R: glyph = 7'h50;
      `FPMC_CH_I: glyph = 7'h30;
      `FPMC_CH_T: glyph = 7'h78;
      `FPMC_CH_U: glyph = 7'h3E;
      `FPMC_CH_OUT: glyph = 7'h01;
      `FPMC_CH_IN: glyph = 7'h08;
      default: glyph = 7'h00;
    endcase
  endfunction

  // menu levels; a new fault outranks any button in the same cycle
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state <= ST_INIT;
      PARAM_GROUP_O <= 8'h0;
      PARAM_OFFSET_O <= 8'h0;
      edit <= 32'h0;
      cursor <= 3'h0;
    end else if (fault_new) begin
      state <= ST_FAULT; // R8
    end else begin
      case (state)
        ST_INIT: if (init_cnt == 32'(INIT_CYCLES - 1)) state <= ST_STATUS; // R5
        ST_STATUS: if (m_press) state <= ST_GROUP; // R13
        ST_GROUP: begin
          if (m_press) state <= ST_STATUS; // R10
          else if (set_ev) state <= ST_OFFSET; // R4
          else if (m_step | up_step) PARAM_GROUP_O <= PARAM_GROUP_O + 8'h1; // R1
          else if (dn_step) PARAM_GROUP_O <= PARAM_GROUP_O - 8'h1;
        end
        ST_OFFSET: begin
          if (m_press) state <= ST_GROUP; // R11
          else if (set_ev) begin
            if (PARAM_GROUP_O[7:6] == `FPMC_CAT_MON) begin
              state <= ST_STATUS; // R7
            end else begin
              state <= ST_VALUE; // R11
              edit <= PARAM_RDATA_I;
              cursor <= 3'h0;
            end
          end else if (up_step) PARAM_OFFSET_O <= PARAM_OFFSET_O + 8'h1;
          else if (dn_step) PARAM_OFFSET_O <= PARAM_OFFSET_O - 8'h1;
        end
        ST_VALUE: begin
          if (m_press) state <= ST_OFFSET; // R12
          else if (up_step) edit <= edit + pow10(cursor); // R2
          else if (dn_step) edit <= edit - pow10(cursor); // R2
          else if (sh_press) cursor <= (cursor == `FPMC_CUR_MAX) ? 3'h0 : cursor + 3'h1; // R3
        end
        ST_FAULT: if (m_press && !blink) state <= ST_GROUP; // R8
        default: state <= ST_STATUS;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) init_cnt <= 32'h0;
    else if (state == ST_INIT) init_cnt <= init_cnt + 32'h1;
  end

  // monitor selection and top-level display mode
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      MON_SELECT_O <= 1'b0;
      MON_GROUP_O <= 8'h0;
      MON_OFFSET_O <= 8'h0;
      disp_mon <= 1'b0;
    end else if (!fault_new) begin
      if (state == ST_OFFSET && !m_press && set_ev && PARAM_GROUP_O[7:6] == `FPMC_CAT_MON) begin
        MON_SELECT_O <= 1'b1; // R7
        MON_GROUP_O <= PARAM_GROUP_O;
        MON_OFFSET_O <= PARAM_OFFSET_O;
        disp_mon <= 1'b1;
      end else if (state == ST_STATUS && !m_press && (up_step | dn_step)) begin
        disp_mon <= ~disp_mon; // R13
      end
    end
  end

  // store strobe carries the edited value; acknowledgement shown afterwards
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      PARAM_STORE_O <= 1'b0;
      PARAM_WDATA_O <= 32'h0;
      ack <= 1'b0;
      ack_cnt <= 32'h0;
    end else begin
      PARAM_STORE_O <= 1'b0;
      if (state == ST_VALUE && set_ev && !m_press && !fault_new) begin
        PARAM_STORE_O <= 1'b1; // R4
        PARAM_WDATA_O <= edit; // R12
        ack <= 1'b1;
        ack_cnt <= 32'h0;
      end else if (state != ST_VALUE || ack_cnt == 32'(ACK_CYCLES - 1) || |prs) begin
        ack <= 1'b0;
      end else begin
        ack_cnt <= ack_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) JOG_O <= 1'b0;
    else if (state != ST_STATUS || m_press) JOG_O <= 1'b0;
    else if (sh_hold) JOG_O <= 1'b1; // R3
  end

  // blinking; a fault arriving with the set press keeps the blink on
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      blink <= 1'b0;
      blink_ph <= 1'b0;
      blink_cnt <= 32'h0;
      fault_q <= 8'h0;
    end else begin
      fault_q <= FAULT_REQ_I;
      if (fault_new) blink <= 1'b1; // R8
      else if (state == ST_FAULT && set_ev) blink <= 1'b0; // R8
      if (blink_cnt == 32'(BLINK_CYCLES - 1)) begin
        blink_cnt <= 32'h0;
        blink_ph <= ~blink_ph;
      end else begin
        blink_cnt <= blink_cnt + 32'h1;
      end
    end
  end

  // paging needs an uninterrupted shift hold; one advance per hold
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      page <= 2'h0;
      page_cnt <= 32'h0;
      page_done <= 1'b0;
    end else begin
      if (!lvl[`FPMC_BTN_SHIFT]) begin
        page_cnt <= 32'h0;
        page_done <= 1'b0;
      end else if (!page_done) begin
        page_cnt <= page_cnt + 32'h1;
      end
      if (m_press || set_ev) begin
        page <= 2'h0;
      end else if (!page_done && page_cnt == 32'(PAGE_HOLD_CYCLES)) begin
        page_done <= 1'b1; // R22
        page <= last_pg ? 2'h0 : page + 2'h1; // R21
      end
    end
  end

  // number source and paging geometry
  assign show_mon = state == ST_STATUS && MON_SELECT_O && (disp_mon || MOTOR_ROTATING_I); // R6
  assign num_src = (state == ST_VALUE) ? edit : MON_VALUE_I;
  assign neg = ((state == ST_VALUE) ? PARAM_SIGNED_I : MON_SIGNED_I) & num_src[31];
  assign mag = neg ? (~num_src) + 32'h1 : num_src;
  assign npages = (bcd[39:32] != 8'h0) ? 2'h3 : (bcd[31:16] != 16'h0) ? 2'h2 : 2'h1;
  assign last_pg = (page + 2'h1) >= npages;
  // the top page reads two digits past the converter; they show as zero
  assign bcd_pad = {8'h00, bcd};

  fpmc_bcd u_bcd (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .bin_i(mag),
    .bcd_o(bcd)
  );

  always_comb begin
    fault_idx = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (FAULT_REQ_I[i]) fault_idx = 3'(i); // R23
    end
  end

  always_comb begin
    ch = {5{`FPMC_CH_BLANK}};
    dp = 5'h0;
    if (state == ST_INIT) begin
      ch = {`FPMC_CH_I, `FPMC_CH_N, `FPMC_CH_I, `FPMC_CH_T, `FPMC_CH_BLANK}; // R5
    end else if (state == ST_FAULT) begin
      ch = {`FPMC_CH_E, `FPMC_CH_R, `FPMC_CH_BLANK, `FPMC_CH_MINUS, {2'h0, fault_idx}}; // R23
    end else if (state == ST_GROUP) begin
      case (PARAM_GROUP_O[7:6])
        2'h0: ch[4] = `FPMC_CH_C; // R9
        2'h1: ch[4] = `FPMC_CH_R;
        2'h2: ch[4] = `FPMC_CH_F;
        default: ch[4] = `FPMC_CH_U;
      endcase
      ch[1] = {3'h0, PARAM_GROUP_O[5:4]}; // R9
      ch[0] = {1'b0, PARAM_GROUP_O[3:0]};
    end else if (state == ST_OFFSET) begin
      ch[1] = {1'b0, PARAM_OFFSET_O[7:4]}; // R11
      ch[0] = {1'b0, PARAM_OFFSET_O[3:0]};
    end else if (state == ST_VALUE && ack) begin
      ch = {`FPMC_CH_BLANK, `FPMC_CH_D, `FPMC_CH_N, `FPMC_CH_E, `FPMC_CH_BLANK}; // R12
    end else if (state == ST_VALUE || show_mon) begin
      dp[0] = neg; // R19
      if (neg && bcd[39:16] == 24'h0) begin
        ch[4] = `FPMC_CH_MINUS; // R19
        for (int i = 0; i < 4; i++) ch[i] = {1'b0, bcd[4*i +: 4]};
      end else if (!neg && bcd[39:20] == 20'h0) begin
        for (int i = 0; i < 5; i++) ch[i] = {1'b0, bcd[4*i +: 4]}; // R20
      end else begin
        ch[4] = {3'h0, page} + 5'h1; // R21
        for (int i = 0; i < 4; i++) ch[i] = {1'b0, bcd_pad[16*page + 4*i +: 4]};
      end
    end else begin
      if (PORT_OUT_LINK_I) ch[4] = `FPMC_CH_OUT; // R15
      else if (PORT_IN_LINK_I) ch[4] = `FPMC_CH_IN;
      dp[4] = HAS_BRAKE_I; // R14
      case (COMM_STATE_I)
        LINK_INIT: ch[3] = 5'h01; // R16
        LINK_PREOP: ch[3] = 5'h02;
        LINK_SAFEOP: ch[3] = 5'h04;
        LINK_OP: ch[3] = 5'h08;
        default: ch[3] = 5'h00;
      endcase
      ch[2] = {2'h0, RUN_MODE_I}; // R17
      case (SERVO_STATE_I)
        CODE_READY: ch[1:0] = {`FPMC_CH_R, `FPMC_CH_D}; // R18
        CODE_RUNNING: ch[1:0] = {`FPMC_CH_R, `FPMC_CH_N};
        default: ch[1:0] = {`FPMC_CH_N, `FPMC_CH_R};
      endcase
    end
  end

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      next_seg[8*i +: 8] = (blink && !blink_ph) ? 8'h00 : {dp[i], glyph(ch[i])}; // R8
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) SEG_O <= 40'h0;
    else SEG_O <= next_seg;
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  init_exit_a: assert property (state == ST_INIT && init_cnt == 32'(INIT_CYCLES - 1)
    |=> state == ST_STATUS) else $error("init did not reach status"); // R5
  group_step_a: assert property (state == ST_GROUP && m_step && !m_press && !set_ev
    && !fault_new |=> PARAM_GROUP_O == $past(PARAM_GROUP_O) + 8'h1)
    else $error("group not stepped on hold"); // R1
  group_exit_a: assert property (state == ST_GROUP && m_press && !fault_new
    |=> state == ST_STATUS) else $error("mode press did not leave group"); // R10
  offset_enter_a: assert property (state == ST_GROUP && set_ev && !m_press && !fault_new
    |=> state == ST_OFFSET) else $error("set did not enter offset"); // R4
  store_strobe_a: assert property (state == ST_VALUE && set_ev && !m_press && !fault_new
    |=> PARAM_STORE_O && PARAM_WDATA_O == $past(edit) ##1 !PARAM_STORE_O)
    else $error("store strobe wrong"); // R12
  fault_entry_a: assert property (fault_new |=> state == ST_FAULT && blink)
    else $error("fault not displayed blinking"); // R8
  blink_stop_a: assert property (state == ST_FAULT && set_ev && !fault_new
    |=> !blink) else $error("set did not stop blinking"); // R8
  mon_auto_a: assert property (state == ST_STATUS && MON_SELECT_O && MOTOR_ROTATING_I && !blink
    |=> SEG_O[38:32] != 7'h00) else $error("monitor not shown while rotating"); // R6
  comm_digit_a: assert property (state == ST_STATUS && !show_mon && COMM_STATE_I == LINK_OP
    |=> SEG_O[30:24] == 7'h7F || blink) else $error("comm digit not 8"); // R16
endmodule

// file: sim/fpmc_operator.sv
// operator model: presses one front-panel button for a given time
// assumes one request at a time, raised between clock edges
`timescale 1ns/100ps
module fpmc_operator (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // request
  input wire logic go_i,
  input wire logic [2:0] key_i,
  input wire logic [7:0] len_i,
  // button levels, high while pressed
  output logic [4:0] btn_o
);
  logic [7:0] left;
  // no chords: a person's single finger keeps the priority logic out of play
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      left <= 8'h00;
      btn_o <= 5'h00;
    end else if (go_i) begin
      left <= len_i;
      btn_o <= 5'h01 << key_i;
    end else if (left > 8'h01) begin
      left <= left - 8'h01;
    end else begin
      left <= 8'h00;
      btn_o <= 5'h00;
    end
  end
endmodule

// file: sim/fpmc_bench.sv
// self-checking bench for the front-panel menu controller
// assumes shortened debounce, init, page, blink and acknowledge counts
`timescale 1ns/100ps
module fpmc_bench;
  import fpmc_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic go = 1'b0;
  logic [2:0] key = 3'h0;
  logic [7:0] len = 8'h00;
  logic [4:0] btn;
  logic [10:0] st = 11'h000;
  logic [7:0] fault = 8'h00;
  logic [31:0] rdata = 32'h00000000;
  logic rsign = 1'b0;
  logic [7:0] grp;
  logic [7:0] ofs;
  logic [31:0] wdata;
  logic store;
  logic msel;
  logic jog;
  logic [39:0] seg;
  logic [23:0] hold_c = 24'h00000F;
  logic [23:0] rep_c = 24'h000007;
  logic rot = 1'b0;
  logic [31:0] mval = 32'h00003039;
  logic msign = 1'b0;
  logic [7:0] mgrp;
  logic [7:0] mofs;
  int fail_count = 0;
  int num_checks = 0;
  int n;
  int on;
  int off;
  // rows: {brake, out, in, comm[2:0], run[2:0], servo[1:0]} beside the status screen
  logic [10:0] row_in [7] = '{11'h004, 11'h629, 11'h14E, 11'h770, 11'h295, 11'h51A, 11'h03F};
  logic [39:0] row_exp [7] = '{40'h003F065450, 40'h81065B505E, 40'h085B4F5054,
    40'h8166665450, 40'h017F6D505E, 40'h883F7D5054, 40'h0006075450};
  always #5 clk = ~clk;
  fpmc_operator op_u (.clk_i(clk), .nrst_i(nrst), .go_i(go), .key_i(key), .len_i(len),
    .btn_o(btn));
  fpmc_top #(.DEB_CYCLES(4), .INIT_CYCLES(20), .PAGE_HOLD_CYCLES(30), .BLINK_CYCLES(8),
    .ACK_CYCLES(10)) dut_u (.CLK_I(clk), .NRST_I(nrst), .BTN_MODE_I(btn[0]),
    .BTN_UP_I(btn[1]), .BTN_DOWN_I(btn[2]), .BTN_SHIFT_I(btn[3]), .BTN_SET_I(btn[4]),
    .HOLD_CYCLES_I(hold_c), .REPEAT_CYCLES_I(rep_c), .HAS_BRAKE_I(st[10]),
    .PORT_OUT_LINK_I(st[9]), .PORT_IN_LINK_I(st[8]), .COMM_STATE_I(fpmc_comm_e'(st[7:5])),
    .RUN_MODE_I(st[4:2]), .SERVO_STATE_I(fpmc_servo_e'(st[1:0])), .MOTOR_ROTATING_I(rot),
    .FAULT_REQ_I(fault), .MON_VALUE_I(mval), .MON_SIGNED_I(msign),
    .PARAM_RDATA_I(rdata), .PARAM_SIGNED_I(rsign), .PARAM_GROUP_O(grp),
    .PARAM_OFFSET_O(ofs), .PARAM_WDATA_O(wdata), .PARAM_STORE_O(store),
    .MON_SELECT_O(msel), .MON_GROUP_O(mgrp), .MON_OFFSET_O(mofs), .JOG_O(jog), .SEG_O(seg));
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(negedge clk);
  endtask
  // press, then leave time for debounce and the menu's two-edge reply
  task automatic push(input logic [2:0] k, input logic [7:0] l, input int post);
    key = k;
    len = l;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    tick(int'(l) + post);
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic count_on(input int c);
    on = 0;
    off = 0;
    for (int i = 0; i < c; i++) begin
      tick(1);
      if (seg === 40'h795000406D) on++;
      if (seg === 40'h0000000000) off++;
    end
  endtask
  initial begin
    tick(12);
    chk(seg, 40'h0000000000);
    nrst = 1'b1;
    tick(2);
    chk(seg, 40'h3054307800);
    tick(30);
    for (int i = 0; i < 7; i++) begin
      st = row_in[i];
      tick(4);
      chk(seg, row_exp[i]);
    end
    push(3'h3, 8'h1C, 15);
    chk({39'h0, jog}, 40'h0000000001);
    push(3'h0, 8'h08, 15);
    chk({39'h0, jog}, 40'h0000000000);
    chk(seg & 40'hFF0000FFFF, 40'h3900003F3F);
    push(3'h0, 8'h1C, 15);
    chk({32'h0, grp}, 40'h0000000002);
    chk(seg & 40'h00000000FF, 40'h000000005B);
    rdata = 32'hFFFFFFD3;
    rsign = 1'b1;
    push(3'h4, 8'h08, 15);
    chk(seg & 40'h000000FFFF, 40'h0000003F3F);
    push(3'h4, 8'h08, 80);
    chk(seg & 40'hFF0000FFFF, 40'h40000066ED);
    push(3'h1, 8'h08, 80);
    chk(seg & 40'h00000000FF, 40'h00000000E6);
    push(3'h3, 8'h08, 15);
    push(3'h1, 8'h08, 80);
    chk(seg & 40'h000000FFFF, 40'h0000004FE6);
    push(3'h4, 8'h08, 0);
    for (n = 0; n < 40 && store !== 1'b1; n++) tick(1);
    if (n == 40) begin
      fail_count++;
      print_verdict();
    end
    chk({8'h00, wdata}, 40'h00FFFFFFDE);
    tick(2);
    chk(seg & 40'h00FFFFFF00, 40'h005E547900);
    tick(15);
    push(3'h0, 8'h08, 15);
    rdata = 32'h0001E240;
    rsign = 1'b0;
    push(3'h4, 8'h08, 80);
    chk(seg & 40'hFF000000FF, 40'h060000007D);
    push(3'h3, 8'h19, 15);
    chk(seg & 40'hFF00000000, 40'h0600000000);
    push(3'h3, 8'h2D, 80);
    chk(seg & 40'hFF0000FFFF, 40'h5B0000065B);
    fault = 8'h24;
    tick(5);
    count_on(32);
    chk(40'(on), 40'h0000000010);
    chk(40'(off), 40'h0000000010);
    push(3'h4, 8'h08, 15);
    count_on(32);
    chk(40'(on), 40'h0000000020);
    push(3'h0, 8'h08, 15);
    chk(seg & 40'hFF00000000, 40'h3900000000);
    push(3'h2, 8'h20, 15);
    chk({32'h0, grp}, 40'h00000000FF);
    chk(seg & 40'hFF0000FFFF, 40'h3E00004F71);
    push(3'h4, 8'h08, 15);
    push(3'h4, 8'h08, 80);
    chk({23'h0, msel, mgrp, mofs}, 40'h000001FF00);
    chk(seg, 40'h065B4F666D);
    push(3'h1, 8'h08, 15);
    chk(seg, 40'h0006075450);
    rot = 1'b1;
    tick(3);
    chk(seg, 40'h065B4F666D);
    rot = 1'b0;
    tick(3);
    chk(seg, 40'h0006075450);
    nrst = 1'b0;
    tick(2);
    chk({21'h0, store, jog, msel, grp, ofs}, 40'h0000000000);
    nrst = 1'b1;
    tick(2);
    chk(seg, 40'h3054307800);
    print_verdict();
  end
endmodule
